// [asc_pkg.sv]
// constants and types for the serial mode and convert start control
package asc_pkg;
    localparam int CTL_BITS = 5;
    localparam int ADDR_BITS = 3;
    localparam int RES_BITS = 12;
    localparam int WORD_BITS = 16;
    localparam int CTL_ADDR_MSB = 4;
    localparam int CTL_ADDR_LSB = 2;
    localparam int MCLK_PERIOD_NS = 50;
    localparam int CONV_TIME_NS = 5900;
    localparam int CONV_CYCLES = CONV_TIME_NS / MCLK_PERIOD_NS;
    localparam int SETTLE_UNIT_NS = 1000;
    localparam int SETTLE_UNIT_CYCLES =
        (SETTLE_UNIT_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
    localparam int SETTLE_W = 16;
    localparam int CONV_W = 8;
    localparam int HALF_W = 5;
    localparam logic [HALF_W-1:0] HALF_LAST = 5'h1F;
    localparam logic [CTL_BITS-1:0] CTL_RESET = 5'h00;
    localparam logic [WORD_BITS-1:0] WORD_RESET = 16'h0000;

    typedef enum logic [1:0] {
        ASC_IDLE = 2'h0,
        ASC_WAIT = 2'h1,
        ASC_CONV = 2'h3,
        ASC_SEND = 2'h2
    } asc_state_type;
endpackage

// [asc_ser_if.sv]
// link between the control core and one serial shifter
`timescale 1ns/1ps
interface asc_ser_if;
    logic clk;
    logic rst;
    logic step;
    logic in_clr;
    logic out_clr;
    logic din;
    logic dout;
    logic dout_en;
    logic [asc_pkg::WORD_BITS-1:0] word;
    logic [asc_pkg::CTL_BITS-1:0] ctl;
    logic ctl_tgl;

    modport core (
        output clk, rst, step, in_clr, out_clr, din, word,
        input dout, dout_en, ctl, ctl_tgl
    );
    modport shf (
        input clk, rst, step, in_clr, out_clr, din, word,
        output dout, dout_en, ctl, ctl_tgl
    );
endinterface

// [asc_shift.sv]
// serial shifter: control word in, result frame out
`timescale 1ns/1ps
module asc_shift (
    asc_ser_if.shf s
);
    logic [2:0] in_cnt;
    logic [4:0] out_cnt;
    logic [asc_pkg::CTL_BITS-1:0] ctl;
    logic ctl_tgl;
    wire in_take = s.step && (in_cnt < 3'(asc_pkg::CTL_BITS));
    wire last_in = in_cnt == 3'(asc_pkg::CTL_BITS - 1);
    wire out_live = out_cnt < 5'(asc_pkg::WORD_BITS);
    wire [3:0] out_pos = 4'(asc_pkg::WORD_BITS - 1) - out_cnt[3:0];

    ////////////////////////////////////////////////////////////////////////
    // input bit count, cleared while transmit frame sync is high
    always_ff @(posedge s.clk or posedge s.in_clr)
    begin
        if (s.in_clr)
            in_cnt <= 3'h0;
        else if (in_take)
            in_cnt <= in_cnt + 3'h1;
    end

    always_ff @(posedge s.clk or posedge s.rst)
    begin
        if (s.rst)
        begin
            ctl <= asc_pkg::CTL_RESET;
            ctl_tgl <= 1'b0;
        end
        else if (in_take && !s.in_clr)
        begin
            ctl <= {ctl[asc_pkg::CTL_BITS-2:0], s.din};
            if (last_in)
                ctl_tgl <= ~ctl_tgl;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // output bit count, cleared while receive frame sync is high
    always_ff @(posedge s.clk or posedge s.out_clr)
    begin
        if (s.out_clr)
            out_cnt <= 5'h00;
        else if (s.step && out_live)
            out_cnt <= out_cnt + 5'h01;
    end

    assign s.dout = out_live ? s.word[out_pos] : 1'b0;
    assign s.dout_en = !s.out_clr;
    assign s.ctl = ctl;
    assign s.ctl_tgl = ctl_tgl;

    a_ctl_ignore_late: assert property (
        @(posedge s.clk) disable iff (s.in_clr)
        (s.step && in_cnt == 3'(asc_pkg::CTL_BITS)) |=> $stable(ctl)
    ) else $error("control bits taken after the fifth");
endmodule

// [asc_top.sv]
// serial mode select and convert start control of the converter
`timescale 1ns/1ps
module asc_top #(
    parameter int CAP_BITS = 8
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic serial_mode_select,
    input wire logic convert_start_input,
    input wire logic [CAP_BITS-1:0] settling_pulse_capacitor,
    input wire logic [asc_pkg::RES_BITS-1:0] sample_value,
    input wire logic sclk_in,
    input wire logic receive_frame_sync_in_n,
    input wire logic transmit_frame_sync_n,
    input wire logic data_in,
    output logic sclk_out,
    output logic sclk_oe,
    output logic receive_frame_sync_out_n,
    output logic receive_frame_sync_oe,
    output logic data_out,
    output logic data_out_oe,
    output logic track_hold,
    output logic busy
);
    if (CAP_BITS < 1 || CAP_BITS > 8)
        $error("CAP_BITS must lie between 1 and 8");

    localparam int CONV_N = asc_pkg::CONV_CYCLES;

    asc_pkg::asc_state_type state;
    asc_pkg::asc_state_type next_state;
    logic mode_s1, mode_s;
    logic cst_s1, cst_s2, cst_d;
    logic tfs_s1, tfs_s;
    logic [CAP_BITS-1:0] cap_s1, cap_s;
    logic tg_s1, tg_s2, tg_slave_prev, tg_master_prev;
    logic conv_pend;
    logic [asc_pkg::SETTLE_W-1:0] settle_cnt;
    logic [asc_pkg::CONV_W-1:0] conv_cnt;
    logic [asc_pkg::HALF_W-1:0] half;
    logic sclk_r;
    logic rfs_gen_n;
    logic [asc_pkg::CTL_BITS-1:0] ctl_word;
    logic [asc_pkg::WORD_BITS-1:0] result_word;

    asc_ser_if sl_if ();
    asc_ser_if ms_if ();

    ////////////////////////////////////////////////////////////////////////
    // pin and slave control toggle synchronisers
    always_ff @(posedge mclk)
    begin
        mode_s1 <= serial_mode_select;
        mode_s <= mode_s1;
        cst_s1 <= convert_start_input;
        cst_s2 <= cst_s1;
        cst_d <= cst_s2;
        tfs_s1 <= transmit_frame_sync_n;
        tfs_s <= tfs_s1;
        cap_s1 <= settling_pulse_capacitor;
        cap_s <= cap_s1;
        tg_s1 <= sl_if.ctl_tgl;
        tg_s2 <= tg_s1;
    end

    ////////////////////////////////////////////////////////////////////////
    // control word arrival from the active shifter
    wire take_slave = mode_s && (tg_s2 != tg_slave_prev);
    wire take_master = !mode_s && (ms_if.ctl_tgl != tg_master_prev);
    wire ctl_take = take_slave || take_master;
    wire [asc_pkg::CTL_BITS-1:0] ctl_new = mode_s ? sl_if.ctl : ms_if.ctl;
    wire [asc_pkg::SETTLE_W-1:0] settle_load =
        asc_pkg::SETTLE_W'(cap_s) *
        asc_pkg::SETTLE_W'(asc_pkg::SETTLE_UNIT_CYCLES);
    wire settle_busy = settle_cnt != '0;
    wire cst_rise = cst_s2 && !cst_d;
    wire conv_last = conv_cnt == '0;
    wire sclk_fall = (state == asc_pkg::ASC_SEND) && sclk_r;
    wire [asc_pkg::ADDR_BITS-1:0] ctl_addr =
        ctl_word[asc_pkg::CTL_ADDR_MSB:asc_pkg::CTL_ADDR_LSB];

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            tg_slave_prev <= 1'b0;
            tg_master_prev <= 1'b0;
            ctl_word <= asc_pkg::CTL_RESET;
        end
        else
        begin
            tg_slave_prev <= tg_s2;
            tg_master_prev <= ms_if.ctl_tgl;
            if (ctl_take)
                ctl_word <= ctl_new;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // settling pulse, restarted by each new control word
    always_ff @(posedge mclk)
    begin
        if (rst)
            settle_cnt <= '0;
        else if (ctl_take)
            settle_cnt <= settle_load;
        else if (settle_busy)
            settle_cnt <= settle_cnt - 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // conversion sequencer
    always_comb
    begin
        next_state = state;
        unique case (state)
            asc_pkg::ASC_IDLE:
                if (conv_pend)
                    next_state = settle_busy ? asc_pkg::ASC_WAIT
                                             : asc_pkg::ASC_CONV;
            asc_pkg::ASC_WAIT:
                if (!settle_busy)
                    next_state = asc_pkg::ASC_CONV;
            asc_pkg::ASC_CONV:
                if (conv_last)
                    next_state = mode_s ? asc_pkg::ASC_IDLE
                                        : asc_pkg::ASC_SEND;
            asc_pkg::ASC_SEND:
                if (half == asc_pkg::HALF_LAST)
                    next_state = asc_pkg::ASC_IDLE;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            state <= asc_pkg::ASC_IDLE;
            conv_pend <= 1'b0;
            conv_cnt <= '0;
            result_word <= asc_pkg::WORD_RESET;
        end
        else
        begin
            state <= next_state;
            if (cst_rise)
                conv_pend <= 1'b1;
            else if (next_state == asc_pkg::ASC_CONV)
                conv_pend <= 1'b0;
            if (state != asc_pkg::ASC_CONV)
                conv_cnt <= asc_pkg::CONV_W'(asc_pkg::CONV_CYCLES - 1);
            else if (!conv_last)
                conv_cnt <= conv_cnt - 1'b1;
            if (state == asc_pkg::ASC_CONV && conv_last)
                result_word <= {1'b0, ctl_addr, sample_value};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // master mode serial clock and receive frame generation
    always_ff @(posedge mclk)
    begin
        if (rst || state != asc_pkg::ASC_SEND)
        begin
            half <= '0;
            sclk_r <= 1'b1;
            rfs_gen_n <= next_state != asc_pkg::ASC_SEND;
        end
        else if (half == asc_pkg::HALF_LAST)
        begin
            sclk_r <= 1'b1;
            rfs_gen_n <= 1'b1;
        end
        else
        begin
            sclk_r <= ~sclk_r;
            half <= half + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // shifters: slave on the link clock, master on the master clock
    assign sl_if.clk = ~sclk_in;
    assign sl_if.rst = rst;
    assign sl_if.step = 1'b1;
    assign sl_if.in_clr = rst || transmit_frame_sync_n;
    assign sl_if.out_clr = rst || receive_frame_sync_in_n;
    assign sl_if.din = data_in;
    assign sl_if.word = result_word;

    assign ms_if.clk = mclk;
    assign ms_if.rst = rst;
    assign ms_if.step = sclk_fall;
    assign ms_if.in_clr = rst || tfs_s;
    assign ms_if.out_clr = rst || rfs_gen_n;
    assign ms_if.din = data_in;
    assign ms_if.word = result_word;

    asc_shift u_slave (
        .s(sl_if.shf)
    );

    asc_shift u_master (
        .s(ms_if.shf)
    );

    ////////////////////////////////////////////////////////////////////////
    // pins
    assign sclk_out = sclk_r;
    assign sclk_oe = !mode_s;
    assign receive_frame_sync_out_n = rfs_gen_n;
    assign receive_frame_sync_oe = !mode_s;
    assign data_out = mode_s ? sl_if.dout : ms_if.dout;
    assign data_out_oe = mode_s ? sl_if.dout_en : ms_if.dout_en;
    assign track_hold = state == asc_pkg::ASC_CONV;
    assign busy = state != asc_pkg::ASC_IDLE;

    ////////////////////////////////////////////////////////////////////////
    // checks
    a_master_drives_pins: assert property (
        @(posedge mclk) disable iff (rst)
        !mode_s |-> (sclk_oe && receive_frame_sync_oe)
    ) else $error("master mode pins not driven");

    a_slave_pins_input: assert property (
        @(posedge mclk) disable iff (rst)
        mode_s |-> (!sclk_oe && !receive_frame_sync_oe && sclk_out)
    ) else $error("slave mode pins driven");

    a_start_enters_hold: assert property (
        @(posedge mclk) disable iff (rst)
        (state == asc_pkg::ASC_IDLE && conv_pend && !settle_busy)
            |=> track_hold
    ) else $error("hold not entered after convert start");

    a_hold_waits_settle: assert property (
        @(posedge mclk) disable iff (rst)
        $rose(track_hold) |-> !$past(settle_busy) && $past(conv_pend)
    ) else $error("hold entered during settling pulse");

    a_settle_length: assert property (
        @(posedge mclk) disable iff (rst)
        ctl_take |=> settle_cnt == $past(settle_load) && settle_busy
            == ($past(cap_s) != '0)
    ) else $error("settling pulse length wrong");

    a_conv_length: assert property (
        @(posedge mclk) disable iff (rst)
        $rose(track_hold) |-> ##CONV_N $fell(track_hold)
    ) else $error("conversion length wrong");

    a_sclk_from_mclk: assert property (
        @(posedge mclk) disable iff (rst)
        (state == asc_pkg::ASC_SEND && half != asc_pkg::HALF_LAST)
            |=> sclk_r != $past(sclk_r)
    ) else $error("master serial clock not toggling");

    a_frame_length: assert property (
        @(posedge mclk) disable iff (rst)
        $fell(rfs_gen_n) |-> ##32 $rose(rfs_gen_n)
    ) else $error("master frame length wrong");
endmodule

// [asc_partner.sv]
// serial port model on the far side of the converter link
`timescale 1ns/1ps
module asc_partner (
    input wire logic mode,
    input wire logic sclk_out,
    input wire logic rfs_out_n,
    input wire logic data_out,
    output logic sclk_in,
    output logic rfs_in_n,
    output logic tfs_n,
    output logic data_in
);
    logic [15:0] rx;
    logic [15:0] tx;
    event fifth;
    initial
    begin
        sclk_in = 1'b1;
        rfs_in_n = 1'b1;
        tfs_n = 1'b1;
        data_in = 1'b0;
        rx = 16'h0000;
        tx = 16'h0000;
    end
    ////////////////////////////////////////////////////////////////////////
    // master mode: take result bits, feed control bits after each fall
    always @(negedge rfs_out_n or posedge sclk_out)
    begin
        #10;
        if (!rfs_out_n && mode == 1'b0)
            rx = {rx[14:0], data_out};
    end
    always @(negedge sclk_out)
    begin
        #5;
        if (!tfs_n && mode == 1'b0)
        begin
            data_in = tx[15];
            tx = {tx[14:0], 1'b0};
        end
    end
    task master_arm(input logic [4:0] ctl);
        tx = {ctl, 11'h555};
        data_in = tx[15];
        tx = {tx[14:0], 1'b0};
        tfs_n = 1'b0;
    endtask
    task master_disarm();
        tfs_n = 1'b1;
        data_in = ~data_in;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // slave mode frame, both frame syncs driven together
    task slave_frame(input logic [4:0] ctl);
        tx = {ctl, 11'h2AA};
        data_in = tx[15];
        tx = {tx[14:0], 1'b0};
        tfs_n = 1'b0;
        rfs_in_n = 1'b0;
        for (int i = 1; i <= 16; i++)
        begin
            #80;
            rx = {rx[14:0], data_out};
            sclk_in = 1'b0;
            if (i == 5)
                ->fifth;
            #5;
            data_in = tx[15];
            tx = {tx[14:0], 1'b0};
            #75;
            sclk_in = 1'b1;
        end
        #80;
        rfs_in_n = 1'b1;
        tfs_n = 1'b1;
        data_in = ~data_in;
    endtask
endmodule

// [test_adc_serial_mode_and_convert_start.sv]
// testbench for the serial mode and convert start control
`timescale 1ns/1ps
module test_adc_serial_mode_and_convert_start;
    logic mclk, rst, mode, cs, sclk_out, sclk_oe, rfs_out_n, rfs_oe;
    logic data_out, data_out_oe, track_hold, busy;
    logic sclk_in, rfs_in_n, tfs_n, data_in;
    logic [7:0] cap;
    logic [11:0] sample;
    int miscompares = 0;
    int checks = 0;
    int cyc = 0;
    int t5, t0, lat, hi;
    asc_top #(.CAP_BITS(8)) i_dut (.mclk(mclk), .rst(rst),
        .serial_mode_select(mode), .convert_start_input(cs),
        .settling_pulse_capacitor(cap), .sample_value(sample),
        .sclk_in(sclk_in), .receive_frame_sync_in_n(rfs_in_n),
        .transmit_frame_sync_n(tfs_n), .data_in(data_in),
        .sclk_out(sclk_out), .sclk_oe(sclk_oe),
        .receive_frame_sync_out_n(rfs_out_n),
        .receive_frame_sync_oe(rfs_oe), .data_out(data_out),
        .data_out_oe(data_out_oe), .track_hold(track_hold), .busy(busy));
    asc_partner i_partner (.mode(mode), .sclk_out(sclk_out),
        .rfs_out_n(rfs_out_n), .data_out(data_out), .sclk_in(sclk_in),
        .rfs_in_n(rfs_in_n), .tfs_n(tfs_n), .data_in(data_in));
    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    always @(posedge mclk)
        cyc <= cyc + 1;
    ////////////////////////////////////////////////////////////////////////
    task check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task stop_test();
        if (miscompares == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task pulse_conv();
        lat = 0;
        hi = 0;
        @(negedge mclk) cs = 1'b1;
        while (track_hold !== 1'b1 && lat < 3000)
        begin
            @(negedge mclk);
            lat++;
            if (lat == 4)
                cs = 1'b0;
        end
        cs = 1'b0;
        while (track_hold === 1'b1 && hi < 3000)
        begin
            @(negedge mclk);
            hi++;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    task t_reset();
        check(sclk_out, 1'b1);
        check(rfs_out_n, 1'b1);
        check(track_hold, 1'b0);
        check(busy, 1'b0);
        check(data_out_oe, 1'b0);
        check({sclk_oe, rfs_oe}, 2'h3);
    endtask
    task t_master(input logic [11:0] smp, input logic [14:0] exp);
        int n, falls, oe_ok;
        logic prev;
        n = 0;
        falls = 0;
        oe_ok = 1;
        prev = 1'b1;
        sample = smp;
        pulse_conv();
        check(hi, asc_pkg::CONV_CYCLES);
        check(busy, 1'b1);
        while (rfs_out_n !== 1'b0 && n < 10)
        begin
            @(negedge mclk);
            n++;
        end
        check(n, 0);
        n = 0;
        while (rfs_out_n === 1'b0 && n < 100)
        begin
            if (data_out_oe !== 1'b1)
                oe_ok = 0;
            @(negedge mclk);
            n++;
            if (prev === 1'b1 && sclk_out === 1'b0)
                falls++;
            prev = sclk_out;
        end
        check(n, 32);
        check(falls, 16);
        check(oe_ok, 1);
        check({sclk_out, data_out_oe}, 2'h2);
        check(i_partner.rx, {1'b0, exp});
    endtask
    task t_slave(input logic [4:0] ctl, input logic [14:0] exp);
        fork
            i_partner.slave_frame(ctl);
            begin
                #400;
                check(data_out_oe, 1'b1);
            end
            begin
                @(i_partner.fifth);
                t5 = cyc;
            end
        join
        @(negedge mclk);
        check(data_out_oe, 1'b0);
        check({sclk_oe, rfs_oe}, 2'h0);
        check(i_partner.rx, {1'b0, exp});
    endtask
    task t_settle();
        int d;
        t0 = cyc;
        sample = 12'h7E1;
        pulse_conv();
        d = t0 + lat - t5;
        check(d >= 80 && d <= 95, 1'b1);
        check(lat > 5, 1'b1);
        check(hi, asc_pkg::CONV_CYCLES);
        check(busy, 1'b0);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        #(20000 * 50);
        miscompares++;
        stop_test();
    end
    initial
    begin
        rst = 1'b1;
        mode = 1'b0;
        cs = 1'b0;
        cap = 8'h00;
        sample = 12'h000;
        repeat (20) @(negedge mclk);
        t_reset();
        rst = 1'b0;
        repeat (5) @(negedge mclk);
        i_partner.master_arm(5'h16);
        repeat (5) @(negedge mclk);
        t_master(12'hA5C, {3'h0, 12'hA5C});
        check(lat, 4);
        i_partner.master_disarm();
        repeat (20) @(negedge mclk);
        t_master(12'h3C1, {3'h5, 12'h3C1});
        cap = 8'h04;
        mode = 1'b1;
        repeat (10) @(negedge mclk);
        #7;
        t_slave(5'h0D, {3'h5, 12'h3C1});
        t_settle();
        repeat (10) @(negedge mclk);
        #13;
        t_slave(5'h0D, {3'h3, 12'h7E1});
        stop_test();
    end
endmodule
